// ### logic/lsd_decoder.sv
// Line state decoder and detect output multiplexer
`timescale 1ns/1ps

// How it works
// - Two control inputs decode to open circuit, active, ringing and stand-by.
// - Open circuit: amplifiers off, line high impedance, no detector, detect high.
// - Ringing: relay on, ring trip active, line high impedance, no transmission.
// - Active: normal transmission, loop current and ground key detectors active.
// - Stand-by: amplifiers off, resistive feed, both loop detectors stay active.
// - Enable low drives detect output; enable high leaves only the pull-up.
// - With enable high detectors stay active but detect output stays high.
// - Select low routes ground key; high routes loop current or ring trip.
// - Enabled detect output is low when triggered, high when not.
// - Ring trip tripped when sense input falls below reference input.
// - Loop detector triggers when sensed voltage exceeds the internal reference.
module lsd_decoder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrl_in_a,
  input wire logic ctrl_in_b,
  input wire logic detect_out_enable_n,
  input wire logic detector_select,
  input wire logic gnd_key_trip,
  input wire logic signed [lsd_pkg::LSD_MV_W-1:0] loop_sense_mv,
  input wire logic signed [lsd_pkg::LSD_MV_W-1:0] ringtrip_sense_in,
  input wire logic signed [lsd_pkg::LSD_MV_W-1:0] ringtrip_ref_in,
  output lsd_pkg::lsd_state_e line_state,
  output lsd_pkg::lsd_line_s line_ctrl,
  output logic tip_drive,
  output logic ring_drive,
  output logic detect_out_n,
  output logic detect_out_oe_n
);

  lsd_pkg::lsd_ctrl_s ctl;
  logic loop_trip;
  logic rt_trip;
  logic sel_valid;
  logic sel_trip;

  assign ctl = '{ctrl: {ctrl_in_a, ctrl_in_b}, detect_out_enable_n: detect_out_enable_n,
                 detector_select: detector_select};

  assign line_state = lsd_pkg::lsd_state_e'(ctl.ctrl);

  a_decode_open: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_in_a && !ctrl_in_b) |-> (line_state == lsd_pkg::LSD_OPEN))
    else $error("open code decoded wrong");

  a_decode_active: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_in_a && ctrl_in_b) |-> (line_state == lsd_pkg::LSD_ACTIVE))
    else $error("active code decoded wrong");

  a_decode_ring: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_in_a && !ctrl_in_b) |-> (line_state == lsd_pkg::LSD_RINGING))
    else $error("ringing code decoded wrong");

  a_decode_standby: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_in_a && ctrl_in_b) |-> (line_state == lsd_pkg::LSD_STANDBY))
    else $error("standby code decoded wrong");

  // Comparators
  assign loop_trip = loop_sense_mv > lsd_pkg::LSD_LOOP_REF_MV;
  assign rt_trip = ringtrip_sense_in < ringtrip_ref_in;

  always_comb
  begin
    line_ctrl = '0;
    case (line_state)
      lsd_pkg::LSD_OPEN:
      begin
        line_ctrl = '0;
      end
      lsd_pkg::LSD_ACTIVE:
      begin
        line_ctrl.amp_power = 1'b1;
        line_ctrl.line_drive_en = 1'b1;
        line_ctrl.transmit_en = 1'b1;
        line_ctrl.gnd_key_active = 1'b1;
        line_ctrl.loop_cur_active = 1'b1;
      end
      lsd_pkg::LSD_RINGING:
      begin
        line_ctrl.ring_relay_on = 1'b1;
        line_ctrl.ringtrip_active = 1'b1;
      end
      lsd_pkg::LSD_STANDBY:
      begin
        line_ctrl.resistive_feed = 1'b1;
        line_ctrl.gnd_key_active = 1'b1;
        line_ctrl.loop_cur_active = 1'b1;
      end
      default:
      begin
        line_ctrl = '0;
      end
    endcase
  end

  // Line terminals only carry drive while amplifiers are connected
  assign tip_drive = line_ctrl.line_drive_en;
  assign ring_drive = line_ctrl.line_drive_en;

  // Detector routing; unselected or inactive reads as not triggered
  always_comb
  begin
    sel_valid = 1'b0;
    sel_trip = 1'b0;
    if (ctl.detector_select == lsd_pkg::LSD_SEL_GND_KEY)
    begin
      sel_valid = line_ctrl.gnd_key_active;
      sel_trip = gnd_key_trip;
    end
    else if (line_ctrl.ringtrip_active)
    begin
      sel_valid = 1'b1;
      sel_trip = rt_trip;
    end
    else
    begin
      sel_valid = line_ctrl.loop_cur_active;
      sel_trip = loop_trip;
    end
  end

  // Disabled output floats to the internal pull-up
  assign detect_out_oe_n = detect_out_enable_n;
  assign detect_out_n = ctl.detect_out_enable_n ? 1'b1 : ~(sel_valid & sel_trip);

  a_open_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_in_a && !ctrl_in_b) |-> (detect_out_n && line_ctrl == '0 && !tip_drive))
    else $error("open circuit not quiet");

  a_ring_setup: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_in_a && !ctrl_in_b) |-> (line_ctrl.ring_relay_on && !ring_drive &&
      !line_ctrl.transmit_en && (detector_select || detect_out_n)))
    else $error("ringing state wrong");

  a_active_setup: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_in_a && ctrl_in_b) |-> (line_ctrl.transmit_en && line_ctrl.gnd_key_active &&
      line_ctrl.loop_cur_active && tip_drive))
    else $error("active state wrong");

  a_standby_setup: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_in_a && ctrl_in_b) |-> (line_ctrl.resistive_feed && !line_ctrl.amp_power &&
      line_ctrl.loop_cur_active && line_ctrl.gnd_key_active))
    else $error("standby state wrong");

  a_disabled_high: assert property (@(posedge clk) disable iff (!arst_n)
    detect_out_enable_n |-> (detect_out_n && detect_out_oe_n))
    else $error("disabled detect not high");

  a_gnd_key_route: assert property (@(posedge clk) disable iff (!arst_n)
    (!detect_out_enable_n && !detector_select && ctrl_in_b) |->
      (detect_out_n == !gnd_key_trip))
    else $error("ground key not routed");

  a_loop_route: assert property (@(posedge clk) disable iff (!arst_n)
    (!detect_out_enable_n && detector_select && ctrl_in_b) |->
      (detect_out_n == (loop_sense_mv <= lsd_pkg::LSD_LOOP_REF_MV)))
    else $error("loop current not routed");

  a_ringtrip_route: assert property (@(posedge clk) disable iff (!arst_n)
    (!detect_out_enable_n && detector_select && ctrl_in_a && !ctrl_in_b) |->
      (detect_out_n == (ringtrip_sense_in >= ringtrip_ref_in)))
    else $error("ring trip not routed");

  a_follow_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
    line_state == lsd_pkg::lsd_state_e'({ctrl_in_a, ctrl_in_b}))
    else $error("state decode lags inputs");

  a_open_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_in_a && !ctrl_in_b) |-> (!tip_drive && !ring_drive && !line_ctrl.amp_power))
    else $error("open circuit drives line");

  a_ring_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_in_a && !ctrl_in_b) |-> (!tip_drive && !line_ctrl.amp_power &&
      !line_ctrl.gnd_key_active && !line_ctrl.loop_cur_active))
    else $error("ringing state not isolated");

  a_standby_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_in_a && ctrl_in_b) |-> (!tip_drive && !ring_drive && !line_ctrl.line_drive_en))
    else $error("standby drives line");

  a_enabled_drive: assert property (@(posedge clk) disable iff (!arst_n)
    !detect_out_enable_n |-> !detect_out_oe_n)
    else $error("enabled detect not driven");

  a_detectors_kept: assert property (@(posedge clk) disable iff (!arst_n)
    detect_out_enable_n |-> (line_ctrl.gnd_key_active == ctrl_in_b &&
      line_ctrl.loop_cur_active == ctrl_in_b &&
      line_ctrl.ringtrip_active == (ctrl_in_a && !ctrl_in_b)))
    else $error("detectors dropped while disabled");

  a_select_gnd_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (!detect_out_enable_n && !detector_select && !ctrl_in_b) |-> detect_out_n)
    else $error("ground key routed without detector");

  a_low_means_trip: assert property (@(posedge clk) disable iff (!arst_n)
    !detect_out_n |-> (!detect_out_enable_n && (gnd_key_trip ||
      loop_sense_mv > lsd_pkg::LSD_LOOP_REF_MV || ringtrip_sense_in < ringtrip_ref_in)))
    else $error("detect low without trip");

  a_amp_only_active: assert property (@(posedge clk) disable iff (!arst_n)
    line_ctrl.amp_power |-> (line_state == lsd_pkg::LSD_ACTIVE))
    else $error("amplifiers on outside active");

  a_transmit_only_active: assert property (@(posedge clk) disable iff (!arst_n)
    line_ctrl.transmit_en |-> (line_state == lsd_pkg::LSD_ACTIVE))
    else $error("transmission outside active");

  a_drive_only_active: assert property (@(posedge clk) disable iff (!arst_n)
    (tip_drive || ring_drive) |-> (line_state == lsd_pkg::LSD_ACTIVE))
    else $error("line driven outside active");

  a_relay_only_ring: assert property (@(posedge clk) disable iff (!arst_n)
    line_ctrl.ring_relay_on |-> (line_state == lsd_pkg::LSD_RINGING))
    else $error("ring relay on outside ringing");

  a_ringtrip_only_ring: assert property (@(posedge clk) disable iff (!arst_n)
    line_ctrl.ringtrip_active |-> (line_state == lsd_pkg::LSD_RINGING))
    else $error("ring trip active outside ringing");

  a_feed_only_standby: assert property (@(posedge clk) disable iff (!arst_n)
    line_ctrl.resistive_feed |-> (line_state == lsd_pkg::LSD_STANDBY))
    else $error("resistive feed outside standby");

endmodule

// ### logic/lsd_pkg.sv
// Package with line state codes, detector levels and carrier structs
package lsd_pkg;

  // Line state from {ctrl_in_a, ctrl_in_b}
  typedef enum logic [1:0] {
    LSD_OPEN    = 2'b00,
    LSD_ACTIVE  = 2'b01,
    LSD_RINGING = 2'b10,
    LSD_STANDBY = 2'b11
  } lsd_state_e;

  // Sensed voltages in millivolts, two's complement
  localparam int LSD_MV_W = 12;
  localparam logic signed [LSD_MV_W-1:0] LSD_LOOP_REF_MV = 12'sh4E2;

  // Detector routing selector values
  localparam logic LSD_SEL_GND_KEY = 1'b0;
  localparam logic LSD_SEL_LOOP_RT = 1'b1;

  typedef struct packed {
    logic [1:0] ctrl;        // {ctrl_in_a, ctrl_in_b}
    logic detect_out_enable_n;
    logic detector_select;
  } lsd_ctrl_s;

  typedef struct packed {
    logic amp_power;         // Line drive amplifiers powered and connected
    logic line_drive_en;     // tip_drive and ring_drive driving the line
    logic transmit_en;       // Voice transmission enabled
    logic ring_relay_on;     // Ring relay driver energised
    logic resistive_feed;    // Resistive loop feed engaged
    logic gnd_key_active;
    logic loop_cur_active;
    logic ringtrip_active;
  } lsd_line_s;

endpackage

// ### testbench/lsd_ctrl_model.sv
// Line card controller model judging off-hook from detect duty cycle
`timescale 1ns/1ps
module lsd_ctrl_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic detect_out_n,
  output logic off_hook
);
  logic [3:0] n_win;
  logic [4:0] n_low;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      n_win <= 4'h0;
      n_low <= 5'h00;
      off_hook <= 1'b0;
    end
    else
    begin
      n_win <= n_win + 4'h1;
      n_low <= (n_win == 4'hF) ? 5'h00 : n_low + {4'h0, ~detect_out_n};
      if (n_win == 4'hF)
        off_hook <= (n_low + {4'h0, ~detect_out_n}) > 5'h08;
    end
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the line state decoder
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, arst_n = 1'b0, ctrl_in_a = 1'b0, ctrl_in_b = 1'b0;
  logic detect_out_enable_n = 1'b0, detector_select = 1'b0, gnd_key_trip = 1'b0;
  logic signed [lsd_pkg::LSD_MV_W-1:0] loop_sense_mv = '0;
  logic signed [lsd_pkg::LSD_MV_W-1:0] ringtrip_sense_in = '0, ringtrip_ref_in = '0;
  lsd_pkg::lsd_state_e line_state;
  lsd_pkg::lsd_line_s line_ctrl;
  logic tip_drive, ring_drive, detect_out_n, detect_out_oe_n, off_hook;
  int n_fail = 0, tests_run = 0;
  always #2 clk = ~clk;
  lsd_decoder u_lsd_decoder (.clk, .arst_n, .ctrl_in_a, .ctrl_in_b, .detect_out_enable_n,
    .detector_select, .gnd_key_trip, .loop_sense_mv, .ringtrip_sense_in, .ringtrip_ref_in,
    .line_state, .line_ctrl, .tip_drive, .ring_drive, .detect_out_n, .detect_out_oe_n);
  lsd_ctrl_model u_lsd_ctrl_model (.clk, .arst_n, .detect_out_n, .off_hook);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Code is {enable_n, select, a, b}; trig puts every detector just past its threshold
  task automatic drive(input logic [3:0] c, input logic trig);
    @(negedge clk);
    {detect_out_enable_n, detector_select, ctrl_in_a, ctrl_in_b} = c;
    gnd_key_trip = trig;
    loop_sense_mv = trig ? 12'sh4E3 : 12'sh4E2;
    ringtrip_sense_in = trig ? 12'sh063 : 12'sh064;
    ringtrip_ref_in = 12'sh064;
    #1;
  endtask

  // All sixteen codes, each with detectors idle and triggered, one clock cycle per step
  task automatic t_table;
    logic [1:0] s;
    logic exp_n;
    logic [7:0] ec;
    logic [7:0] m;
    for (int i = 0; i < 32; i++)
    begin
      drive(i[4:1], i[0]);
      s = i[2:1];
      exp_n = i[4] | ~(i[0] & (i[3] ? s != 2'b00 : s[0]));
      ec = s == 2'b01 ? 8'hE6 : s == 2'b10 ? 8'h11 : s == 2'b11 ? 8'h0E : 8'h00;
      m = s == 2'b11 ? 8'hDF : s == 2'b10 ? 8'h7F : 8'hFF;
      chk({6'h00, line_state}, {6'h00, s}, "state");
      chk(line_ctrl & m, ec, "line control");
      chk({6'h00, tip_drive, ring_drive}, {6'h00, {2{s == 2'b01}}}, "drive");
      chk({6'h00, detect_out_n, detect_out_oe_n}, {6'h00, exp_n, i[4]}, "det");
    end
  endtask

  // Ring trip toggling with n_lo low cycles of every sixteen
  task automatic t_duty(input int n_lo, input logic exp);
    for (int k = 0; k < 48; k++)
      drive(4'b0110, (k % 16) < n_lo);
    @(posedge clk);
    #1;
    chk({7'h00, off_hook}, {7'h00, exp}, "off-hook");
  endtask

  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_table;
    t_duty(9, 1'b1);
    t_duty(8, 1'b0);
    wrap_up;
  end
endmodule
